// >>> hdl/stu_pkg.sv
// constants, types and register map of the scan timer unit
package stu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and time bases
  localparam int unsigned STU_CLK_PERIOD_NS = 50;
  localparam int unsigned STU_BASE0_NS = 10000000;
  localparam int unsigned STU_BASE0_CYC = STU_BASE0_NS / STU_CLK_PERIOD_NS;
  localparam int unsigned STU_DECADE = 10;
  localparam int unsigned STU_NUM_BASES = 4;
  localparam int unsigned STU_MAX_TIMERS = 128;
  localparam int unsigned STU_SMALL_TIMERS = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [7:0] STU_REG_CMD = 8'h00;
  localparam logic [7:0] STU_REG_ACCU = 8'h04;
  localparam logic [7:0] STU_REG_SEL = 8'h08;
  localparam logic [7:0] STU_REG_SCAN = 8'h0C;

  // command register fields
  localparam int unsigned STU_CMD_OP_LSB = 0;
  localparam int unsigned STU_CMD_RLO_BIT = 8;
  localparam int unsigned STU_CMD_IDX_LSB = 16;
  localparam int unsigned STU_IDX_W = 7;

  // scan register fields
  localparam int unsigned STU_SCAN_Q_BIT = 0;
  localparam int unsigned STU_SCAN_RUN_BIT = 1;
  localparam int unsigned STU_SCAN_DONE_BIT = 2;
  localparam int unsigned STU_SCAN_CNT_LSB = 16;

  // reset values
  localparam logic [15:0] STU_ACCU_RST = 16'h0000;
  localparam logic [6:0] STU_SEL_RST = 7'h00;

  // axi responses
  localparam logic [1:0] STU_RESP_OKAY = 2'b00;
  localparam logic [1:0] STU_RESP_SLVERR = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // timer operations, one-hot
  typedef enum logic [7:0] {
    STU_OP_PULSE = 8'h01,
    STU_OP_EXT_PULSE = 8'h02,
    STU_OP_ON_DELAY = 8'h04,
    STU_OP_STORED = 8'h08,
    STU_OP_OFF_DELAY = 8'h10,
    STU_OP_RESET = 8'h20,
    STU_OP_LOAD_BIN = 8'h40,
    STU_OP_LOAD_BCD = 8'h80
  } stu_op_t;

  // time value word as held in accumulator_one
  typedef struct packed {
    logic [1:0] ignored;
    logic [1:0] base;
    logic [11:0] bcd;
  } stu_time_t;

  typedef struct packed {
    logic [7:0] op;
    logic logic_result;
    logic [6:0] idx;
  } stu_cmd_t;

  typedef struct packed {
    stu_op_t mode;
    logic run;
    logic done;
    logic logic_result;
    logic [1:0] base;
    logic [11:0] cnt;
    logic [11:0] init;
  } stu_tmr_t;

  localparam stu_tmr_t STU_TMR_RST = '{mode: STU_OP_RESET, default: '0};

endpackage

// >>> hdl/stu_timer_bank.sv
// bank of scan timers behind an axi4-lite slave
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module stu_timer_bank
  import stu_pkg::*;
#(
  parameter int unsigned N_TIMERS = stu_pkg::STU_MAX_TIMERS,
  parameter int unsigned TICK_CYC = stu_pkg::STU_BASE0_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import stu_pkg::*;

  localparam int unsigned PRE_W = $clog2(TICK_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (N_TIMERS != STU_SMALL_TIMERS && N_TIMERS != STU_MAX_TIMERS) begin : g_bad_n
    $error("N_TIMERS must be 32 or 128");
  end
  if (TICK_CYC < 2) begin : g_bad_tick
    $error("TICK_CYC must be at least 2");
  end
  if ((1 << STU_IDX_W) != STU_MAX_TIMERS) begin : g_bad_idx
    $error("index field must address every timer");
  end
  if (STU_NUM_BASES != 4) begin : g_bad_base
    $error("time base code is two bits wide");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [11:0] bcd_dec(input logic [11:0] v);
    logic [11:0] r;
    logic borrow;
    r = v;
    // borrow ripples up from the lowest digit
    borrow = 1'b1;
    for (int k = 0; k < 3; k++) begin
      if (borrow) begin
        if (r[4*k +: 4] == 4'h0) begin
          r[4*k +: 4] = 4'h9;
        end else begin
          r[4*k +: 4] = r[4*k +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    return r;
  endfunction

  function automatic logic [9:0] bcd_to_bin(input logic [11:0] v);
    return 10'(v[11:8]) * 10'd100 + 10'(v[7:4]) * 10'd10 + 10'(v[3:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // time base prescaler, free running so a start lands anywhere in a tick
  logic [PRE_W-1:0] pre_r;
  logic [3:0] dec_r [1:STU_NUM_BASES-1];
  logic [STU_NUM_BASES-1:0] tick;
  wire pre_wrap = (pre_r == PRE_W'(TICK_CYC - 1));

  assign tick[0] = pre_wrap;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= '0;
    end else if (pre_wrap) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + PRE_W'(1);
    end
  end

  for (genvar b = 1; b < STU_NUM_BASES; b++) begin : g_decade
    wire dec_wrap = (dec_r[b] == 4'(STU_DECADE - 1));
    assign tick[b] = tick[b-1] && dec_wrap;
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        dec_r[b] <= 4'h0;
      end else if (tick[b-1]) begin
        dec_r[b] <= dec_wrap ? 4'h0 : dec_r[b] + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken together
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic [15:0] accu_r;
  logic [15:0] accu_nxt;
  logic [6:0] sel_r;

  wire aw_is_cmd = (s_axi_awaddr == STU_REG_CMD);
  wire aw_is_accu = (s_axi_awaddr == STU_REG_ACCU);
  wire aw_is_sel = (s_axi_awaddr == STU_REG_SEL);
  wire aw_is_scan = (s_axi_awaddr == STU_REG_SCAN);
  // both halves taken at one edge, so a response never runs ahead of its data
  wire wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  wire wr_cmd = wr_fire && aw_is_cmd && s_axi_wstrb[0];
  wire wr_accu = wr_fire && aw_is_accu;
  wire wr_sel = wr_fire && aw_is_sel && s_axi_wstrb[0];
  wire wr_map = aw_is_cmd || aw_is_accu || aw_is_sel || aw_is_scan;

  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= STU_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_map ? STU_RESP_OKAY : STU_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  stu_cmd_t cmd;
  assign cmd.op = s_axi_wdata[STU_CMD_OP_LSB +: 8];
  assign cmd.logic_result = s_axi_wdata[STU_CMD_RLO_BIT];
  assign cmd.idx = s_axi_wdata[STU_CMD_IDX_LSB +: STU_IDX_W];

  wire cmd_fire = wr_cmd && (32'(cmd.idx) < N_TIMERS);
  wire stu_time_t accu_tw = accu_r;

  ////////////////////////////////////////////////////////////////////////////
  // timer array
  stu_tmr_t tmr [STU_MAX_TIMERS];
  logic [STU_MAX_TIMERS-1:0] scan_q;

  for (genvar i = 0; i < STU_MAX_TIMERS; i++) begin : g_tmr
    if (i < N_TIMERS) begin : g_on
      stu_tmr_t st_r;
      stu_tmr_t st_nxt;
      wire hit = cmd_fire && (cmd.idx == 7'(i));
      // one edge bit per timer, shared by every start operation
      wire rise = hit && cmd.logic_result && !st_r.logic_result;
      wire fall = hit && !cmd.logic_result && st_r.logic_result;
      wire rise_op = (cmd.op == STU_OP_PULSE) || (cmd.op == STU_OP_EXT_PULSE)
                  || (cmd.op == STU_OP_ON_DELAY) || (cmd.op == STU_OP_STORED);

      always_comb begin
        st_nxt = st_r;
        // countdown on the selected base
        if (st_r.run && tick[st_r.base]) begin
          if (st_r.cnt <= 12'h001) begin
            st_nxt.cnt = 12'h000;
            st_nxt.run = 1'b0;
            st_nxt.done = 1'b1;
          end else begin
            st_nxt.cnt = bcd_dec(st_r.cnt);
          end
        end
        if (hit && rise_op) begin
          st_nxt.logic_result = cmd.logic_result;
          if (rise) begin
            // (re)start from accumulator_one
            st_nxt.mode = stu_op_t'(cmd.op);
            st_nxt.init = accu_tw.bcd;
            st_nxt.base = accu_tw.base;
            st_nxt.cnt = accu_tw.bcd;
            st_nxt.run = (accu_tw.bcd != 12'h000);
            st_nxt.done = (accu_tw.bcd == 12'h000);
          end else if (!cmd.logic_result && cmd.op == STU_OP_PULSE) begin
            st_nxt.cnt = 12'h000;
            st_nxt.run = 1'b0;
            st_nxt.done = 1'b0;
          end else if (!cmd.logic_result && cmd.op == STU_OP_ON_DELAY) begin
            st_nxt.run = 1'b0;
            st_nxt.done = 1'b0;
          end
        end else if (hit && cmd.op == STU_OP_OFF_DELAY) begin
          st_nxt.logic_result = cmd.logic_result;
          st_nxt.mode = STU_OP_OFF_DELAY;
          if (cmd.logic_result) begin
            // held at the initial value while input is 1
            st_nxt.init = accu_tw.bcd;
            st_nxt.base = accu_tw.base;
            st_nxt.cnt = accu_tw.bcd;
            st_nxt.run = 1'b0;
            st_nxt.done = 1'b0;
          end else if (fall) begin
            st_nxt.cnt = st_r.init;
            st_nxt.run = (st_r.init != 12'h000);
            st_nxt.done = (st_r.init == 12'h000);
          end
        // reset also clears the edge bit so a later start counts as rising
        end else if (hit && cmd.op == STU_OP_RESET && cmd.logic_result) begin
          st_nxt.cnt = st_r.init;
          st_nxt.run = 1'b0;
          st_nxt.done = 1'b0;
          st_nxt.logic_result = 1'b0;
        end
      end

      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          st_r <= STU_TMR_RST;
        end else begin
          st_r <= st_nxt;
        end
      end

      assign tmr[i] = st_r;

      // boolean scan output per start mode
      always_comb begin
        unique case (st_r.mode)
          STU_OP_PULSE: scan_q[i] = st_r.run;
          STU_OP_EXT_PULSE: scan_q[i] = st_r.run;
          STU_OP_ON_DELAY: scan_q[i] = st_r.done && st_r.logic_result;
          STU_OP_STORED: scan_q[i] = st_r.done;
          STU_OP_OFF_DELAY: scan_q[i] = st_r.logic_result || st_r.run;
          default: scan_q[i] = 1'b0;
        endcase
      end
    end else begin : g_off
      // absent timers read as idle
      assign tmr[i] = STU_TMR_RST;
      assign scan_q[i] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator_one and selection register
  wire stu_tmr_t cmd_tmr = tmr[cmd.idx];
  wire ld_bin = cmd_fire && (cmd.op == STU_OP_LOAD_BIN);
  wire ld_bcd = cmd_fire && (cmd.op == STU_OP_LOAD_BCD);

  always_comb begin
    accu_nxt = accu_r;
    if (ld_bin) begin
      accu_nxt = {6'h00, bcd_to_bin(cmd_tmr.cnt)};
    end else if (ld_bcd) begin
      accu_nxt = {2'b00, cmd_tmr.base, cmd_tmr.cnt};
    end else if (wr_accu) begin
      for (int k = 0; k < 2; k++) begin
        if (s_axi_wstrb[k]) begin
          accu_nxt[8*k +: 8] = s_axi_wdata[8*k +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      accu_r <= STU_ACCU_RST;
      sel_r <= STU_SEL_RST;
    end else begin
      accu_r <= accu_nxt;
      if (wr_sel) begin
        sel_r <= s_axi_wdata[6:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  wire rd_fire = s_axi_arvalid && !rvalid_r;
  wire stu_tmr_t sel_tmr = tmr[sel_r];
  wire ar_is_cmd = (s_axi_araddr == STU_REG_CMD);
  wire ar_is_accu = (s_axi_araddr == STU_REG_ACCU);
  wire ar_is_sel = (s_axi_araddr == STU_REG_SEL);
  wire ar_is_scan = (s_axi_araddr == STU_REG_SCAN);
  wire [2:0] scan_bits = {sel_tmr.done, sel_tmr.run, scan_q[sel_r]};
  wire [31:0] scan_word = {4'h0, sel_tmr.cnt, 13'h0, scan_bits};
  wire rd_map = ar_is_cmd || ar_is_accu || ar_is_sel || ar_is_scan;
  // read word latched at the take edge so rdata stands until rready
  wire [31:0] rd_word = ar_is_accu ? {16'h0000, accu_r} :
                        ar_is_sel ? {25'h0, sel_r} :
                        ar_is_scan ? scan_word : 32'h00000000;

  assign s_axi_arready = rd_fire;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= STU_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_map ? STU_RESP_OKAY : STU_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule // stu_timer_bank

// >>> verification/stu_assertions.sv
// bus handshake checks of the scan timer bank
`timescale 1ns/1ps
module stu_chk
  import stu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  wire wt = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire rt = s_axi_arvalid && !s_axi_rvalid;
  wire wbad = !(s_axi_awaddr inside {STU_REG_CMD, STU_REG_ACCU, STU_REG_SEL, STU_REG_SCAN});
  wire rbad = !(s_axi_araddr inside {STU_REG_CMD, STU_REG_ACCU, STU_REG_SEL, STU_REG_SCAN});
  sequence s_wtake;
    wt;
  endsequence
  sequence s_bwait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  chk_aw_ready: assert property (s_axi_awready == wt) else $error("awready wrong");
  chk_w_ready: assert property (s_axi_wready == wt) else $error("wready wrong");
  chk_ar_ready: assert property (s_axi_arready == rt) else $error("arready wrong");
  chk_b_follow: assert property (s_wtake |=> s_axi_bvalid) else $error("no write answer");
  chk_b_hold: assert property (s_bwait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer lost");
  chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  chk_w_okay: assert property (s_wtake ##0 !wbad |=> s_axi_bresp == STU_RESP_OKAY)
    else $error("mapped write refused");
  chk_w_err: assert property (s_wtake ##0 wbad |=> s_axi_bresp == STU_RESP_SLVERR)
    else $error("unmapped write ok");
  chk_r_err: assert property (rt && rbad |=> s_axi_rresp == STU_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read ok");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data lost");
endmodule // stu_chk

// >>> verification/stu_exec_model.sv
// bus master model of the instruction execution unit
`timescale 1ns/1ps
module stu_exec_model (
  input wire logic clk_sys,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  output logic tmo
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, tmo} = '0;
  end
  ////////////////////////////////////////
  // a leading edge keeps back-to-back calls apart
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) && n < 200);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1) tmo = 1'b1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) && n < 200);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1) tmo = 1'b1;
  endtask
endmodule // stu_exec_model

// >>> verification/stu_timer_bank_tb.sv
// self-checking bench of the scan timer bank
`timescale 1ns/1ps
module stu_timer_bank_tb;
  import stu_pkg::*;
  localparam int unsigned TK = 10;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tmo;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  stu_timer_bank #(.N_TIMERS(STU_SMALL_TIMERS), .TICK_CYC(TK)) i_stu_timer_bank (.*);
  stu_exec_model i_stu_exec_model (.*);
  ////////////////////////////////////////
  task automatic stop_test();
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
    if (tmo === 1'b1) begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    i_stu_exec_model.wr(a, d, rs);
  endtask
  task automatic get(input logic [7:0] a);
    i_stu_exec_model.rd(a, rv, rs);
  endtask
  task automatic cmd(input logic [7:0] op, input logic l, input logic [6:0] ix);
    put(STU_REG_CMD, {9'h0, ix, 7'h0, l, op});
  endtask
  task automatic scan(input logic [6:0] ix);
    put(STU_REG_SEL, {25'h0, ix});
    get(STU_REG_SCAN);
  endtask
  function automatic logic [15:0] st();
    return {13'h0, rv[2:0]};
  endfunction
  function automatic logic [15:0] cn();
    return {4'h0, rv[27:16]};
  endfunction
  ////////////////////////////////////////
  task automatic t_regs();
    get(STU_REG_ACCU);
    chk("accu rst", STU_ACCU_RST, rv[15:0]);
    get(STU_REG_SEL);
    chk("sel rst", {9'h0, STU_SEL_RST}, rv[15:0]);
    put(8'h10, 32'h0);
    chk("wr unmapped", 16'h2, {14'h0, rs});
    get(8'h10);
    chk("rd unmapped", 16'h2, {14'h0, rs});
    put(STU_REG_ACCU, 32'h9);
    cmd(STU_OP_PULSE, 1'b1, 7'h28);
    scan(7'h08);
    chk("idx over", 16'h0, st());
    cmd(STU_OP_PULSE, 1'b1, 7'h1F);
    scan(7'h1F);
    chk("idx last", 16'h3, st());
  endtask
  task automatic t_pulse();
    cmd(STU_OP_PULSE, 1'b1, 7'h00);
    scan(7'h00);
    chk("pulse run", 16'h3, st());
    chk("pulse val", 16'h9, cn() | 16'h1);
    cmd(STU_OP_PULSE, 1'b0, 7'h00);
    scan(7'h00);
    chk("pulse stop", 16'h0, {15'h0, rv[0]});
  endtask
  task automatic t_ext();
    put(STU_REG_ACCU, 32'h5);
    cmd(STU_OP_EXT_PULSE, 1'b1, 7'h01);
    cmd(STU_OP_EXT_PULSE, 1'b0, 7'h01);
    scan(7'h01);
    chk("ext hold", 16'h3, st());
    repeat (20) @(posedge clk_sys);
    cmd(STU_OP_EXT_PULSE, 1'b1, 7'h01);
    scan(7'h01);
    chk("ext reload", 16'h5, cn() | 16'h1);
    repeat (20) @(posedge clk_sys);
    cmd(STU_OP_EXT_PULSE, 1'b1, 7'h01);
    scan(7'h01);
    chk("ext level", 16'h1, {15'h0, cn() < 16'h4});
    repeat (60) @(posedge clk_sys);
    scan(7'h01);
    chk("ext end", 16'h4, st());
  endtask
  task automatic t_delay();
    put(STU_REG_ACCU, 32'h3);
    cmd(STU_OP_ON_DELAY, 1'b1, 7'h02);
    cmd(STU_OP_STORED, 1'b1, 7'h03);
    cmd(STU_OP_STORED, 1'b0, 7'h03);
    cmd(STU_OP_OFF_DELAY, 1'b1, 7'h04);
    scan(7'h02);
    chk("on wait", 16'h2, st());
    repeat (40) @(posedge clk_sys);
    scan(7'h02);
    chk("on out", 16'h5, st());
    cmd(STU_OP_ON_DELAY, 1'b0, 7'h02);
    scan(7'h02);
    chk("on drop", 16'h0, {15'h0, rv[0]});
    scan(7'h03);
    chk("stored out", 16'h5, st());
    cmd(STU_OP_RESET, 1'b0, 7'h03);
    scan(7'h03);
    chk("rst idle", 16'h5, st());
    cmd(STU_OP_RESET, 1'b1, 7'h03);
    scan(7'h03);
    chk("rst q", 16'h0, st());
    chk("rst init", 16'h3, cn());
    scan(7'h04);
    chk("off held", 16'h1, {15'h0, rv[0]});
    chk("off init", 16'h3, cn());
    cmd(STU_OP_OFF_DELAY, 1'b0, 7'h04);
    scan(7'h04);
    chk("off run", 16'h1, {15'h0, rv[0]});
    repeat (40) @(posedge clk_sys);
    scan(7'h04);
    chk("off end", 16'h0, {15'h0, rv[0]});
  endtask
  task automatic t_load();
    put(STU_REG_ACCU, 32'hF123);
    cmd(STU_OP_EXT_PULSE, 1'b1, 7'h05);
    cmd(STU_OP_LOAD_BCD, 1'b0, 7'h05);
    get(STU_REG_ACCU);
    chk("load bcd", 16'h3123, rv[15:0] | 16'h1);
    cmd(STU_OP_LOAD_BIN, 1'b0, 7'h05);
    get(STU_REG_ACCU);
    chk("load bin", 16'h007B, rv[15:0] | 16'h1);
  endtask
  task automatic t_rst();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    get(STU_REG_ACCU);
    chk("accu rerst", STU_ACCU_RST, rv[15:0]);
    scan(7'h05);
    chk("scan rerst", 16'h0, st());
  endtask
  task automatic t_base();
    int p, c0, e;
    for (int b = 0; b < 4; b++) begin
      p = TK * (10 ** b);
      put(STU_REG_ACCU, {16'h0, 2'h3, b[1:0], 12'h003});
      cmd(STU_OP_RESET, 1'b1, 7'h06);
      c0 = cyc;
      cmd(STU_OP_EXT_PULSE, 1'b1, 7'h06);
      do begin
        scan(7'h06);
        e = cyc - c0;
      end while (rv[2] !== 1'b1 && e < 3 * p + 40);
      chk("base time", 16'h1, {15'h0, e > 2 * p && e <= 3 * p + 20});
    end
  endtask
  // timers 0 to 6 used in ascending order, after timer 31 in t_regs
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_pulse();
    t_ext();
    t_delay();
    t_load();
    t_rst();
    t_base();
    stop_test();
  end
endmodule // stu_timer_bank_tb

bind stu_timer_bank stu_chk i_stu_chk (.*);
